// >>> rtl/tbf_pkg.sv
// Constants, register map and beat layout of the trace bus funnel
package tbf_pkg;
  localparam int          MAX_PORTS      = 8;
  localparam int          IDX_W          = 3;
  localparam int          PRIO_W         = 3;
  localparam int          ADDR_W         = 12;

  // Register byte offsets
  localparam logic [11:0] OFS_CTRL       = 12'h000;
  localparam logic [11:0] OFS_PRIO       = 12'h004;
  localparam logic [11:0] OFS_IT_DATA0   = 12'hEEC;
  localparam logic [11:0] OFS_IT_CTRL2   = 12'hEF0;
  localparam logic [11:0] OFS_IT_CTRL1   = 12'hEF4;
  localparam logic [11:0] OFS_IT_CTRL0   = 12'hEF8;
  localparam logic [11:0] OFS_IT_MODE    = 12'hF00;
  localparam logic [11:0] OFS_CLAIM_SET  = 12'hFA0;
  localparam logic [11:0] OFS_CLAIM_CLR  = 12'hFA4;
  localparam logic [11:0] OFS_LOCK_KEY   = 12'hFB0;
  localparam logic [11:0] OFS_LOCK_STATE = 12'hFB4;
  localparam logic [11:0] OFS_PERMIT     = 12'hFB8;
  localparam logic [11:0] OFS_CAPS       = 12'hFC8;
  localparam logic [11:0] OFS_CLASS      = 12'hFCC;
  localparam logic [11:0] OFS_PID4       = 12'hFD0;
  localparam logic [11:0] OFS_PID0       = 12'hFE0;
  localparam logic [11:0] OFS_PID1       = 12'hFE4;
  localparam logic [11:0] OFS_PID2       = 12'hFE8;
  localparam logic [11:0] OFS_PID3       = 12'hFEC;
  localparam logic [11:0] OFS_CID0       = 12'hFF0;
  localparam logic [11:0] OFS_CID1       = 12'hFF4;
  localparam logic [11:0] OFS_CID2       = 12'hFF8;
  localparam logic [11:0] OFS_CID3       = 12'hFFC;

  // Field positions
  localparam int          CTRL_EN_LSB    = 0;
  localparam int          CTRL_HOLD_LSB  = 8;
  localparam int          IT_VALID_BIT   = 0;
  localparam int          IT_FLUSH_BIT   = 1;
  localparam int          IT_BYTES_LSB   = 8;

  // Reset values and fixed codes
  localparam logic [7:0]  CTRL_EN_RST    = 8'h00;
  localparam logic [3:0]  HOLD_RST       = 4'h0;
  localparam logic [3:0]  HOLD_MAX       = 4'hE;
  localparam logic [3:0]  HOLD_RSVD      = 4'hF;
  localparam logic [23:0] PRIO_RST       = 24'h000000;
  localparam logic [7:0]  CLASS_CODE     = 8'h12;
  localparam logic [3:0]  CAPS_SCHEME    = 4'h0;

  typedef struct packed {
    logic [31:0] data;
    logic [1:0]  bytes;
    logic [6:0]  id;
  } tbf_beat_t;
endpackage : tbf_pkg

// >>> rtl/tbf_grant_sel.sv
// Priority selector: lowest priority value wins, ties to lowest index
`timescale 1ns/100ps
module tbf_grant_sel #(
  parameter int N_PORTS = 8
) (
  input  wire logic [N_PORTS-1:0]          req_in,
  input  wire logic [N_PORTS*3-1:0]        prio_in,
  output logic      [tbf_pkg::IDX_W-1:0]   gnt_idx_out,
  output logic                             gnt_any_out
);
  logic [tbf_pkg::PRIO_W-1:0] best_prio;

  always_comb
  begin
    gnt_idx_out = '0;
    gnt_any_out = 1'b0;
    best_prio   = '0;
    for (int i = 0; i < N_PORTS; i++)
    begin
      // Strict compare keeps the lower index on equal priority
      if (req_in[i] && (!gnt_any_out ||
          prio_in[i*3 +: 3] < best_prio)) // [RQ18]
      begin
        gnt_idx_out = tbf_pkg::IDX_W'(i);
        best_prio   = prio_in[i*3 +: 3];
        gnt_any_out = 1'b1;
      end
    end
  end
endmodule : tbf_grant_sel

// >>> rtl/tbf_funnel.sv
// Trace bus funnel: merges source ports into one sink stream
// Operation
// [RQ1] Merge all input trace ports into one output
// [RQ2] One enable bit per port, eight ports
// [RQ3] Enables reset to zero, all ports off
// [RQ4] Three-bit priority field per input port
// [RQ5] Correct key write unlocks configuration writes
// [RQ6] Locked: ignore writes except key register
// [RQ7] Lock state register always present, readable
// [RQ8] Claim set writes ones; reads tag width
// [RQ9] Claim clear writes ones; reads tag value
// [RQ10] Functional default; integration mode drives pins directly
// [RQ11] Integration reads sample inputs, writes drive outputs
// [RQ12] Read-only trace permission status register
// [RQ13] Read-only capabilities register shows port count
// [RQ14] Read-only component class register
// [RQ15] Read-only peripheral and component identity registers
// [RQ16] Hold source for hold count plus one
// [RQ17] Integration valid bit reads port n, drives output
// [RQ18] Lowest priority value first, ties lowest index
// [RQ19] Sources hold valid and data until accepted
//
// Added by the designer: strobed register access.
`timescale 1ns/100ps
module tbf_funnel #(
  parameter int          N_PORTS    = 8,
  parameter int          CLAIM_BITS = 4,
  parameter logic [31:0] UNLOCK_KEY = 32'h0000A5A5, // Arbitrary value
  parameter logic [31:0] PID0_VAL   = 32'h00000011, // Arbitrary value
  parameter logic [31:0] PID1_VAL   = 32'h00000022, // Arbitrary value
  parameter logic [31:0] PID2_VAL   = 32'h00000033, // Arbitrary value
  parameter logic [31:0] PID3_VAL   = 32'h00000000, // Arbitrary value
  parameter logic [31:0] PID4_VAL   = 32'h00000044, // Arbitrary value
  parameter logic [31:0] CID0_VAL   = 32'h00000055, // Arbitrary value
  parameter logic [31:0] CID1_VAL   = 32'h00000066, // Arbitrary value
  parameter logic [31:0] CID2_VAL   = 32'h00000077, // Arbitrary value
  parameter logic [31:0] CID3_VAL   = 32'h00000088  // Arbitrary value
) (
  input  wire logic                      clock_in,
  input  wire logic                      rstn_in,
  // Register port
  input  wire logic [11:0]               addr_in,
  input  wire logic [31:0]               wr_data_in,
  input  wire logic                      wr_in,
  input  wire logic                      rd_in,
  output logic      [31:0]               rd_data_out,
  // System trace permission level
  input  wire logic [7:0]                permit_in,
  // Source ports
  input  wire logic [N_PORTS-1:0]        src_valid_in,
  input  wire tbf_pkg::tbf_beat_t [N_PORTS-1:0] src_beat_in,
  output logic      [N_PORTS-1:0]        src_ready_out,
  output logic      [N_PORTS-1:0]        src_flush_valid_out,
  input  wire logic [N_PORTS-1:0]        src_flush_ready_in,
  // Sink port
  output logic                           sink_valid_out,
  output tbf_pkg::tbf_beat_t             sink_beat_out,
  input  wire logic                      sink_ready_in,
  input  wire logic                      sink_flush_valid_in,
  output logic                           sink_flush_ready_out
);
  localparam int IW = tbf_pkg::IDX_W;

  if (N_PORTS < 1 || N_PORTS > tbf_pkg::MAX_PORTS)
  begin : g_bad_ports
    $error("tbf_funnel: N_PORTS must be 1 to 8");
  end
  if (CLAIM_BITS < 1 || CLAIM_BITS > 32)
  begin : g_bad_claim
    $error("tbf_funnel: CLAIM_BITS must be 1 to 32");
  end

  localparam logic [7:0] PORT_MASK = 8'((1 << N_PORTS) - 1);
  localparam logic [31:0] CLAIM_MASK = 32'((64'h1 << CLAIM_BITS) - 1);

  // Index of lowest set bit, zero when none
  function automatic logic [IW-1:0] first_set(input logic [7:0] v);
    logic [IW-1:0] r;
    r = '0;
    for (int i = 7; i >= 0; i--)
    begin
      if (v[i])
      begin
        r = IW'(i);
      end
    end
    return r;
  endfunction : first_set

  // Reset release
  logic rst_sync1_q;
  logic rst_sync2_q;
  wire  rstn = rst_sync2_q;

  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      rst_sync1_q <= 1'b0;
      rst_sync2_q <= 1'b0;
    end
    else
    begin
      rst_sync1_q <= 1'b1;
      rst_sync2_q <= rst_sync1_q;
    end
  end

  // Configuration state
  logic [7:0]            en_q;
  logic [3:0]            hold_q;
  logic [23:0]           prio_q;
  logic                  it_mode_q;
  logic [CLAIM_BITS-1:0] claim_q;
  logic                  locked_q;
  logic                  it_valid_q;
  logic                  it_flush_ready_q;
  logic [1:0]            it_bytes_q;
  logic [6:0]            it_id_q;
  logic [31:0]           it_data_q;
  logic                  it_ready_q;
  logic                  it_flush_valid_q;
  logic [31:0]           rd_q;
  logic [31:0]           rd_d;

  // Address decode
  wire hit_ctrl   = addr_in == tbf_pkg::OFS_CTRL;
  wire hit_prio   = addr_in == tbf_pkg::OFS_PRIO;
  wire hit_data0  = addr_in == tbf_pkg::OFS_IT_DATA0;
  wire hit_ctrl2  = addr_in == tbf_pkg::OFS_IT_CTRL2;
  wire hit_ctrl1  = addr_in == tbf_pkg::OFS_IT_CTRL1;
  wire hit_ctrl0  = addr_in == tbf_pkg::OFS_IT_CTRL0;
  wire hit_mode   = addr_in == tbf_pkg::OFS_IT_MODE;
  wire hit_cset   = addr_in == tbf_pkg::OFS_CLAIM_SET;
  wire hit_cclr   = addr_in == tbf_pkg::OFS_CLAIM_CLR;
  wire hit_key    = addr_in == tbf_pkg::OFS_LOCK_KEY;

  // Key register stays writable so a locked block can be reopened
  wire wr_cfg     = wr_in && !locked_q; // [RQ6]
  wire wr_key     = wr_in && hit_key; // [RQ5]

  wire [7:0] en_wr   = wr_data_in[tbf_pkg::CTRL_EN_LSB +: 8] & PORT_MASK;
  wire [3:0] hold_wr = wr_data_in[tbf_pkg::CTRL_HOLD_LSB +: 4];

  always_ff @(posedge clock_in or negedge rstn)
  begin
    if (!rstn)
    begin
      en_q     <= tbf_pkg::CTRL_EN_RST; // [RQ3]
      hold_q   <= tbf_pkg::HOLD_RST;
      prio_q   <= tbf_pkg::PRIO_RST;
      it_mode_q <= 1'b0; // [RQ10]
      claim_q  <= '0;
      locked_q <= 1'b1;
    end
    else
    begin
      if (wr_cfg && hit_ctrl)
      begin
        en_q   <= en_wr; // [RQ2]
        hold_q <= hold_wr;
      end
      if (wr_cfg && hit_prio)
      begin
        prio_q <= wr_data_in[23:0]; // [RQ4]
      end
      if (wr_cfg && hit_mode)
      begin
        it_mode_q <= wr_data_in[0]; // [RQ10]
      end
      if (wr_cfg && hit_cset)
      begin
        claim_q <= claim_q | wr_data_in[CLAIM_BITS-1:0]; // [RQ8]
      end
      if (wr_cfg && hit_cclr)
      begin
        claim_q <= claim_q & ~wr_data_in[CLAIM_BITS-1:0]; // [RQ9]
      end
      if (wr_key)
      begin
        locked_q <= wr_data_in != UNLOCK_KEY; // [RQ5]
      end
    end
  end

  // Integration output drivers
  always_ff @(posedge clock_in or negedge rstn)
  begin
    if (!rstn)
    begin
      it_valid_q       <= 1'b0;
      it_flush_ready_q <= 1'b0;
      it_bytes_q       <= '0;
      it_id_q          <= '0;
      it_data_q        <= '0;
      it_ready_q       <= 1'b0;
      it_flush_valid_q <= 1'b0;
    end
    else
    begin
      if (wr_cfg && hit_ctrl0)
      begin
        it_valid_q       <= wr_data_in[tbf_pkg::IT_VALID_BIT]; // [RQ17]
        it_flush_ready_q <= wr_data_in[tbf_pkg::IT_FLUSH_BIT]; // [RQ11]
        it_bytes_q       <= wr_data_in[tbf_pkg::IT_BYTES_LSB +: 2];
      end
      if (wr_cfg && hit_ctrl1)
      begin
        it_id_q <= wr_data_in[6:0]; // [RQ11]
      end
      if (wr_cfg && hit_ctrl2)
      begin
        it_ready_q       <= wr_data_in[tbf_pkg::IT_VALID_BIT];
        it_flush_valid_q <= wr_data_in[tbf_pkg::IT_FLUSH_BIT];
      end
      if (wr_cfg && hit_data0)
      begin
        it_data_q <= wr_data_in;
      end
    end
  end

  // Arbitration and output stage
  logic               out_valid_q;
  tbf_pkg::tbf_beat_t out_beat_q;
  logic [IW-1:0]      cur_q;
  logic               cur_valid_q;
  logic [3:0]         cnt_q;
  logic [IW-1:0]      best_idx;
  logic               best_any;

  wire [N_PORTS-1:0] req =
    src_valid_in & en_q[N_PORTS-1:0] & {N_PORTS{!it_mode_q}}; // [RQ2]
  // Reserved hold code is served as the largest legal one
  wire [3:0] hold_eff =
    (hold_q == tbf_pkg::HOLD_RSVD) ? tbf_pkg::HOLD_MAX : hold_q;
  // Hold covers hold_eff + 1 beats; an idle source gives up at once
  wire keep  = cur_valid_q && req[cur_q] && (cnt_q <= hold_eff); // [RQ16]
  wire space = !out_valid_q || sink_ready_in;
  wire [IW-1:0] sel = keep ? cur_q : best_idx;
  wire take  = (keep || best_any) && space && !it_mode_q; // [RQ1]

  tbf_grant_sel #(
    .N_PORTS     (N_PORTS)
  ) u_grant (
    .req_in      (req),
    .prio_in     (prio_q[N_PORTS*3-1:0]),
    .gnt_idx_out (best_idx),
    .gnt_any_out (best_any)
  );

  always_ff @(posedge clock_in or negedge rstn)
  begin
    if (!rstn)
    begin
      out_valid_q <= 1'b0;
      out_beat_q  <= '0;
      cur_q       <= '0;
      cur_valid_q <= 1'b0;
      cnt_q       <= '0;
    end
    else
    begin
      if (take)
      begin
        // Source keeps beat stable until this cycle
        out_beat_q  <= src_beat_in[sel]; // [RQ19]
        out_valid_q <= 1'b1;
        cur_q       <= sel;
        cur_valid_q <= 1'b1;
        cnt_q       <= keep ? cnt_q + 4'h1 : 4'h1; // [RQ16]
      end
      else
      begin
        if (sink_ready_in || it_mode_q)
        begin
          out_valid_q <= 1'b0;
        end
        if (!keep)
        begin
          cur_valid_q <= 1'b0;
        end
      end
    end
  end

  // Port side drivers
  wire [N_PORTS-1:0] sel_onehot = N_PORTS'(1) << sel;
  wire [N_PORTS-1:0] en_ports   = en_q[N_PORTS-1:0];

  assign src_ready_out = it_mode_q ? {N_PORTS{it_ready_q}} // [RQ10]
                       : (take ? sel_onehot : '0);
  assign src_flush_valid_out = it_mode_q ? {N_PORTS{it_flush_valid_q}}
                             : en_ports & {N_PORTS{sink_flush_valid_in}};
  assign sink_flush_ready_out = it_mode_q ? it_flush_ready_q
                              : &(src_flush_ready_in | ~en_ports);
  assign sink_valid_out = it_mode_q ? it_valid_q : out_valid_q; // [RQ17]
  assign sink_beat_out  = it_mode_q
                        ? {it_data_q, it_bytes_q, it_id_q} // [RQ11]
                        : out_beat_q;

  // Integration reads look at the lowest enabled port
  wire [IW-1:0]       it_port = first_set(en_q);
  tbf_pkg::tbf_beat_t it_beat;
  assign it_beat = src_beat_in[it_port];

  wire [31:0] rd_ctrl  = {20'h00000, hold_q, en_q};
  wire [31:0] rd_ctrl0 = {22'h000000, it_beat.bytes, 6'h00,
                          src_flush_ready_in[it_port],
                          src_valid_in[it_port]}; // [RQ17]
  wire [31:0] rd_ctrl1 = {25'h0000000, it_beat.id};
  wire [31:0] rd_ctrl2 = {30'h00000000, sink_flush_valid_in,
                          sink_ready_in}; // [RQ11]
  wire [31:0] rd_claim = 32'(claim_q);
  wire [31:0] rd_lock  = {29'h00000000, 1'b0, locked_q, 1'b1}; // [RQ7]
  wire [31:0] rd_caps  = {24'h000000, tbf_pkg::CAPS_SCHEME,
                          4'(N_PORTS)}; // [RQ13]

  always_comb
  begin
    case (addr_in)
      tbf_pkg::OFS_CTRL:       rd_d = rd_ctrl;
      tbf_pkg::OFS_PRIO:       rd_d = {8'h00, prio_q};
      tbf_pkg::OFS_IT_DATA0:   rd_d = it_beat.data; // [RQ11]
      tbf_pkg::OFS_IT_CTRL2:   rd_d = rd_ctrl2;
      tbf_pkg::OFS_IT_CTRL1:   rd_d = rd_ctrl1;
      tbf_pkg::OFS_IT_CTRL0:   rd_d = rd_ctrl0;
      tbf_pkg::OFS_IT_MODE:    rd_d = {31'h00000000, it_mode_q};
      tbf_pkg::OFS_CLAIM_SET:  rd_d = CLAIM_MASK; // [RQ8]
      tbf_pkg::OFS_CLAIM_CLR:  rd_d = rd_claim; // [RQ9]
      tbf_pkg::OFS_LOCK_STATE: rd_d = rd_lock; // [RQ7]
      tbf_pkg::OFS_PERMIT:     rd_d = {24'h000000, permit_in}; // [RQ12]
      tbf_pkg::OFS_CAPS:       rd_d = rd_caps;
      tbf_pkg::OFS_CLASS:      rd_d = 32'(tbf_pkg::CLASS_CODE); // [RQ14]
      tbf_pkg::OFS_PID4:       rd_d = PID4_VAL; // [RQ15]
      tbf_pkg::OFS_PID0:       rd_d = PID0_VAL;
      tbf_pkg::OFS_PID1:       rd_d = PID1_VAL;
      tbf_pkg::OFS_PID2:       rd_d = PID2_VAL;
      tbf_pkg::OFS_PID3:       rd_d = PID3_VAL;
      tbf_pkg::OFS_CID0:       rd_d = CID0_VAL;
      tbf_pkg::OFS_CID1:       rd_d = CID1_VAL;
      tbf_pkg::OFS_CID2:       rd_d = CID2_VAL;
      tbf_pkg::OFS_CID3:       rd_d = CID3_VAL;
      default:                 rd_d = 32'h00000000;
    endcase
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge clock_in or negedge rstn)
  begin
    if (!rstn)
    begin
      rd_q <= 32'h00000000;
    end
    else
    begin
      rd_q <= rd_in ? rd_d : 32'h00000000;
    end
  end

  assign rd_data_out = rd_q;
endmodule : tbf_funnel

// >>> tb/tbf_monitor.sv
// Port-level checker for the trace bus funnel
`timescale 1ns/100ps
module tbf_monitor #(
  parameter int          N_PORTS    = 8,
  parameter logic [31:0] UNLOCK_KEY = 32'h0000A5A5
) (
  input wire logic                              clock_in,
  input wire logic                              rstn_in,
  input wire logic [11:0]                       addr_in,
  input wire logic [31:0]                       wr_data_in,
  input wire logic                              wr_in,
  input wire logic                              rd_in,
  input wire logic [31:0]                       rd_data_out,
  input wire logic [7:0]                        permit_in,
  input wire logic [N_PORTS-1:0]                src_valid_in,
  input wire tbf_pkg::tbf_beat_t [N_PORTS-1:0]  src_beat_in,
  input wire logic [N_PORTS-1:0]                src_ready_out,
  input wire logic                              sink_valid_out,
  input wire tbf_pkg::tbf_beat_t                sink_beat_out,
  input wire logic                              sink_ready_in
);
  logic               locked_q;
  logic               mode_q;
  logic [7:0]         en_q;
  tbf_pkg::tbf_beat_t pick;
  wire                ok_wr = wr_in && !locked_q;
  wire                fn    = !mode_q;

  // Shadow of lock, mode and enables, snooped off the register port
  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      locked_q <= 1'b1;
      mode_q   <= 1'b0;
      en_q     <= 8'h00;
    end
    else
    begin
      if (wr_in && addr_in == tbf_pkg::OFS_LOCK_KEY)
        locked_q <= (wr_data_in != UNLOCK_KEY);
      if (ok_wr && addr_in == tbf_pkg::OFS_IT_MODE)
        mode_q <= wr_data_in[0];
      if (ok_wr && addr_in == tbf_pkg::OFS_CTRL)
        en_q <= wr_data_in[7:0];
    end
  end

  always_comb
  begin
    pick = '0;
    for (int i = 0; i < N_PORTS; i++)
      if (src_ready_out[i])
        pick = pick | src_beat_in[i];
  end

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rstn_in);

  sequence s_rd(logic [11:0] a);
    rd_in && addr_in == a;
  endsequence

  a_rd_idle_zero: assert property (!rd_in |=> rd_data_out == 32'h0)
    else $error("read data not zero outside a read answer");
  a_disabled_idle: assert property (
    fn |-> (src_ready_out & ~en_q) == '0)
    else $error("disabled port was accepted");
  a_one_grant: assert property (fn |-> $onehot0(src_ready_out))
    else $error("more than one port accepted");
  a_grant_valid: assert property (
    fn |-> (src_ready_out & ~src_valid_in) == '0)
    else $error("ready given to an idle port");
  a_beat_moves: assert property (fn && |src_ready_out |=>
    sink_valid_out && sink_beat_out == $past(pick))
    else $error("accepted beat not on sink");
  a_sink_holds: assert property (
    fn && !wr_in && sink_valid_out && !sink_ready_in |=>
    sink_valid_out && $stable(sink_beat_out))
    else $error("sink beat changed while stalled");
  a_no_overrun: assert property (
    fn && sink_valid_out && !sink_ready_in |-> src_ready_out == '0)
    else $error("source accepted while sink stalled");
  a_lock_report: assert property (s_rd(tbf_pkg::OFS_LOCK_STATE) |=>
    rd_data_out == {30'h0, $past(locked_q), 1'b1})
    else $error("lock state read wrong");
  a_permit_read: assert property (s_rd(tbf_pkg::OFS_PERMIT) |=>
    rd_data_out[7:0] == $past(permit_in))
    else $error("permission read wrong");
  a_caps_read: assert property (s_rd(tbf_pkg::OFS_CAPS) |=>
    rd_data_out[3:0] == 4'(N_PORTS))
    else $error("port count read wrong");
  a_enable_read: assert property (s_rd(tbf_pkg::OFS_CTRL) |=>
    rd_data_out[7:0] == $past(en_q))
    else $error("enables read wrong");
endmodule : tbf_monitor

bind tbf_funnel tbf_monitor #(.N_PORTS(N_PORTS), .UNLOCK_KEY(UNLOCK_KEY))
  u_tbf_monitor (.clock_in, .rstn_in, .addr_in, .wr_data_in, .wr_in,
    .rd_in, .rd_data_out, .permit_in, .src_valid_in, .src_beat_in,
    .src_ready_out, .sink_valid_out, .sink_beat_out, .sink_ready_in);

// >>> tb/tbf_partner.sv
// Trace sources and trace sink on the far side of the funnel
`timescale 1ns/100ps
module tbf_partner #(
  parameter int N = 8
) (
  input  wire logic                   clock_in,
  input  wire logic                   rstn_in,
  output logic [N-1:0]                src_valid_out,
  output tbf_pkg::tbf_beat_t [N-1:0]  src_beat_out,
  input  wire logic [N-1:0]           src_ready_in,
  input  wire logic [N-1:0]           flush_valid_in,
  output logic [N-1:0]                flush_ready_out,
  input  wire logic                   sink_valid_in,
  input  wire tbf_pkg::tbf_beat_t     sink_beat_in,
  output logic                        sink_ready_out
);
  int                 left [N];
  logic [7:0]         seq  [N];
  logic               slow = 1'b0;
  logic               tog_q;
  tbf_pkg::tbf_beat_t got  [$];

  // Sources keep no backlog, so a flush completes at once
  assign flush_ready_out = flush_valid_in;
  assign sink_ready_out  = !slow || tog_q;

  always_comb
    for (int i = 0; i < N; i++)
    begin
      src_valid_out[i] = left[i] > 0;
      src_beat_out[i]  = '{data: {16'h0, 8'(i), seq[i]}, bytes: 2'h3,
                            id: 7'(i)};
      // Idle lines show junk so a stale beat cannot pass
      if (!src_valid_out[i])
        src_beat_out[i] = ~src_beat_out[i];
    end

  always @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      tog_q <= 1'b0;
      for (int i = 0; i < N; i++)
      begin
        left[i] <= 0;
        seq[i]  <= 8'h00;
      end
    end
    else
    begin
      tog_q <= !tog_q;
      if (sink_valid_in && sink_ready_out)
        got.push_back(sink_beat_in);
      for (int i = 0; i < N; i++)
        if (src_valid_out[i] && src_ready_in[i])
        begin
          left[i] <= left[i] - 1;
          seq[i]  <= seq[i] + 8'h01;
        end
    end
  end
endmodule : tbf_partner

// >>> tb/tbf_funnel_tb.sv
// Self-checking bench for the trace bus funnel
`timescale 1ns/100ps
`define CHK(nm, exp, got) \
  begin \
    n_tests++; \
    if ((got) !== (exp)) \
    begin \
      errors++; \
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got); \
    end \
  end
module tbf_funnel_tb;
  localparam logic [31:0] KEY = 32'h0000A5A5; // Arbitrary value
  localparam logic [11:0] ID_OFS [9] = '{12'hFD0, 12'hFE0, 12'hFE4,
    12'hFE8, 12'hFEC, 12'hFF0, 12'hFF4, 12'hFF8, 12'hFFC};
  localparam logic [7:0]  ID_VAL [9] = '{8'h44, 8'h11, 8'h22, 8'h33,
    8'h00, 8'h55, 8'h66, 8'h77, 8'h88};
  logic                     clock_in = 1'b0;
  logic                     rstn_in  = 1'b0;
  logic [11:0]              addr_in  = 12'h000;
  logic [31:0]              wdata    = 32'h0;
  logic                     wr_in    = 1'b0;
  logic                     rd_in    = 1'b0;
  logic [31:0]              rdata;
  logic [7:0]               valid, ready, flv, flr;
  tbf_pkg::tbf_beat_t [7:0] beat;
  tbf_pkg::tbf_beat_t       sbeat;
  logic                     svalid, sready, sflr;
  logic                     sflv     = 1'b0;
  logic [7:0]               permit   = 8'h5A;
  int                       errors   = 0;
  int                       n_tests  = 0;
  int                       cycles   = 0;

  tbf_funnel #(.UNLOCK_KEY(KEY)) u_tbf_funnel (
    .clock_in, .rstn_in, .addr_in, .wr_data_in(wdata), .wr_in, .rd_in,
    .rd_data_out(rdata), .permit_in(permit), .src_valid_in(valid),
    .src_beat_in(beat), .src_ready_out(ready), .src_flush_valid_out(flv),
    .src_flush_ready_in(flr), .sink_valid_out(svalid),
    .sink_beat_out(sbeat), .sink_ready_in(sready),
    .sink_flush_valid_in(sflv), .sink_flush_ready_out(sflr));
  tbf_partner u_tbf_partner (
    .clock_in, .rstn_in, .src_valid_out(valid), .src_beat_out(beat),
    .src_ready_in(ready), .flush_valid_in(flv), .flush_ready_out(flr),
    .sink_valid_in(svalid), .sink_beat_in(sbeat), .sink_ready_out(sready));

  initial
  begin
    forever #25 clock_in = !clock_in;
  end

  // Whole run needs well under a thousand cycles
  always @(posedge clock_in)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      errors++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : stop_test

  // Idle edge after the strobe keeps back-to-back calls race free
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    addr_in <= a;
    wdata   <= d;
    wr_in   <= 1'b1;
    @(posedge clock_in);
    wr_in   <= 1'b0;
    @(posedge clock_in);
  endtask : wr

  task automatic rchk(input string nm, input logic [11:0] a,
                      input logic [31:0] e);
    addr_in <= a;
    rd_in   <= 1'b1;
    @(posedge clock_in);
    rd_in   <= 1'b0;
    #1;
    `CHK(nm, e, rdata)
    @(posedge clock_in);
  endtask : rchk

  task automatic order(input string nm, input logic [6:0] e [$]);
    for (int k = 0; k < 60 && u_tbf_partner.got.size() < e.size(); k++)
      @(posedge clock_in);
    repeat (4) @(posedge clock_in);
    `CHK(nm, e.size(), u_tbf_partner.got.size())
    foreach (e[i])
      `CHK(nm, e[i], u_tbf_partner.got[i].id)
    u_tbf_partner.got.delete();
  endtask : order

  task automatic t_regs();
    rchk("ctrl", 12'h000, 32'h0);
    rchk("lock", 12'hFB4, 32'h3);
    rchk("claim bits", 12'hFA0, 32'hF);
    rchk("permit", 12'hFB8, 32'h5A);
    permit <= 8'hA5;
    rchk("permit", 12'hFB8, 32'hA5);
    rchk("caps", 12'hFC8, 32'h8);
    rchk("class", 12'hFCC, 32'h12);
    rchk("unmapped", 12'h100, 32'h0);
    foreach (ID_OFS[i])
      rchk("ident", ID_OFS[i], {24'h0, ID_VAL[i]});
  endtask : t_regs

  task automatic t_lock();
    wr(12'h000, 32'h3);
    rchk("ctrl locked", 12'h000, 32'h0);
    wr(12'hFB0, 32'h1234);
    rchk("bad key", 12'hFB4, 32'h3);
    wr(12'hFB0, KEY);
    rchk("unlocked", 12'hFB4, 32'h1);
    wr(12'h004, 32'h00FAC688);
    rchk("prio", 12'h004, 32'h00FAC688);
    wr(12'hFCC, 32'h0);
    rchk("class ro", 12'hFCC, 32'h12);
  endtask : t_lock

  task automatic t_claim();
    wr(12'hFA0, 32'h5);
    rchk("claim set", 12'hFA4, 32'h5);
    wr(12'hFA4, 32'h3);
    rchk("claim clr", 12'hFA4, 32'h4);
  endtask : t_claim

  task automatic t_hold();
    wr(12'h004, 32'h8);
    wr(12'h000, 32'h103);
    u_tbf_partner.left[1] <= 4;
    @(posedge clock_in);
    u_tbf_partner.left[0] <= 2;
    u_tbf_partner.left[2] <= 3;
    order("hold", '{1, 1, 0, 0, 1, 1});
    `CHK("disabled", 3, u_tbf_partner.left[2])
  endtask : t_hold

  task automatic t_prio();
    wr(12'h004, 32'h4A);
    wr(12'h000, 32'h0);
    u_tbf_partner.slow    <= 1'b1;
    u_tbf_partner.left[0] <= 1;
    u_tbf_partner.left[1] <= 1;
    u_tbf_partner.left[3] <= 1;
    wr(12'h000, 32'hF);
    order("prio", '{3, 1, 2, 2, 2, 0});
    u_tbf_partner.slow    <= 1'b0;
  endtask : t_prio

  task automatic t_integ();
    wr(12'hF00, 32'h1);
    u_tbf_partner.left[0] <= 1;
    rchk("it src", 12'hEF8, 32'h301);
    rchk("it data", 12'hEEC, 32'h3);
    sflv <= 1'b1;
    rchk("it sink", 12'hEF0, 32'h3);
    wr(12'hEF8, 32'h3);
    #1;
    `CHK("it drive", 2'b11, {svalid, sflr})
    wr(12'hEEC, 32'h89ABCDEF);
    wr(12'hEF4, 32'h55);
    `CHK("it beat", {32'h89ABCDEF, 2'h0, 7'h55}, sbeat)
    wr(12'hEF0, 32'h1);
    #1;
    `CHK("it ready", 8'hFF, ready)
    wr(12'hEF0, 32'h0);
    wr(12'hEF8, 32'h0);
    wr(12'hF00, 32'h0);
    #1;
    // Flush request fans out to the enabled ports only
    `CHK("flush fan", 9'h1F, {flv, sflr})
    sflv <= 1'b0;
  endtask : t_integ

  initial
  begin
    repeat (8) @(posedge clock_in);
    rstn_in <= 1'b1;
    repeat (3) @(posedge clock_in);
    t_regs();
    t_lock();
    t_claim();
    t_hold();
    t_prio();
    t_integ();
    stop_test();
  end
endmodule : tbf_funnel_tb
